/* File: core/slc_top.sv */
// Status indicator encoder and automatic address configuration sequencer.
// Operation
// - Several active conditions: show pattern of the highest priority one.
// - Acquisition in progress outranks address-assigned indication.
// - Waiting for an address shows slow flashing blue.
// - No Ethernet link shows fast flashing blue.
// - Address assigned, no application connected shows steady blue.
// - Application connected idle steady green; triggered acquisition slow green.
// - Free-running acquisition shows fast flashing green.
// - Host control accepted only after address assigned; host must wait.
// - Address sequence starts at power-up and on every link up.
// - Order: stored static address if enabled, then DHCP, then link-local.
// - Defaults: static address off, DHCP on; link-local always on.
// - Link-local picks random 169.254 address, reprobes on any ARP reply.
`include "slc_defs.svh"
`default_nettype none
module slc_top
  import slc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_up_pin,
  input wire slc_status_t status,
  input wire logic static_en,
  input wire logic dhcp_en,
  input wire logic [31:0] static_addr,
  input wire slc_net_ans_t net_ans,
  output slc_net_req_t net_req,
  output logic [31:0] ip_addr,
  output logic ip_valid,
  output logic host_ctrl_accept,
  output logic led_red,
  output logic led_green,
  output logic led_blue
);

  typedef enum logic [2:0] {
    SLC_IDLE, SLC_STATIC, SLC_DHCP, SLC_DHCP_WAIT, SLC_LL_PICK,
    SLC_LL_WAIT, SLC_BOUND
  } slc_state_t;

  //////////////////////////////////////////////////////////////////////////
  // Link pin synchroniser; the second stage and the third (edge-detect) stage are read by logic.
  logic link_s1, link_s2, link_prev;
  logic next_link_s1, next_link_s2, next_link_prev;
  always_comb begin
    next_link_s1 = link_up_pin;
    next_link_s2 = link_s1;
    next_link_prev = link_s2;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_s1 <= 1'b0;
      link_s2 <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      link_s1 <= next_link_s1;
      link_s2 <= next_link_s2;
      link_prev <= next_link_prev;
    end
  end
  wire logic link_rise = link_s2 & ~link_prev;

  //////////////////////////////////////////////////////////////////////////
  // Address sequencer. Power-up starts it once; a new link restarts it.
  slc_state_t state, next_state;
  logic boot_pending, next_boot_pending;
  logic [15:0] lfsr, next_lfsr;
  logic [31:0] addr, next_addr;
  slc_net_req_t next_req;
  always_comb begin
    next_state = state;
    next_boot_pending = boot_pending;
    next_addr = addr;
    next_req = '0;
    next_req.probe_addr = net_req.probe_addr;
    // Free-running generator, so each probe draws a fresh value.
    next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ `SLC_LFSR_TAPS) : (lfsr >> 1);
    if (!link_s2) begin
      // Losing the link drops the address; it is reacquired on link up.
      next_state = SLC_IDLE;
    end else if (link_rise || boot_pending) begin
      next_boot_pending = 1'b0;
      next_state = SLC_STATIC;
    end else begin
      unique case (state)
        SLC_IDLE: begin
          next_state = SLC_IDLE;
        end
        SLC_STATIC: begin
          if (static_en) begin
            next_addr = static_addr;
            next_state = SLC_BOUND;
          end else begin
            next_state = SLC_DHCP;
          end
        end
        SLC_DHCP: begin
          if (dhcp_en) begin
            next_req.dhcp_start = 1'b1;
            next_state = SLC_DHCP_WAIT;
          end else begin
            next_state = SLC_LL_PICK;
          end
        end
        SLC_DHCP_WAIT: begin
          if (net_ans.dhcp_done) begin
            next_addr = net_ans.dhcp_addr;
            next_state = SLC_BOUND;
          end else if (net_ans.dhcp_fail) begin
            next_state = SLC_LL_PICK;
          end
        end
        SLC_LL_PICK: begin
          // Third-octet values 0 and 255 are reserved in the link-local range.
          next_req.probe_addr = {`SLC_LL_PREFIX, lfsr};
          if (lfsr[15:8] != 8'h00 && lfsr[15:8] != 8'hff) begin
            next_req.arp_probe = 1'b1;
            next_state = SLC_LL_WAIT;
          end
        end
        SLC_LL_WAIT: begin
          if (net_ans.arp_done) begin
            if (net_ans.arp_reply) begin
              next_state = SLC_LL_PICK;
            end else begin
              next_addr = net_req.probe_addr;
              next_state = SLC_BOUND;
            end
          end
        end
        SLC_BOUND: begin
          next_state = SLC_BOUND;
        end
        default: begin
          next_state = SLC_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SLC_IDLE;
      boot_pending <= 1'b1;
      lfsr <= `SLC_LFSR_SEED;
      addr <= 32'h0;
      net_req <= '0;
    end else begin
      state <= next_state;
      boot_pending <= next_boot_pending;
      lfsr <= next_lfsr;
      addr <= next_addr;
      net_req <= next_req;
    end
  end

  // Host control is gated by the bound address.
  assign ip_valid = (state == SLC_BOUND);
  assign ip_addr = addr;
  assign host_ctrl_accept = ip_valid;

  //////////////////////////////////////////////////////////////////////////
  // Flash phase generators; one loop covers both rates.
  localparam int unsigned HALF [2] = '{`SLC_SLOW_HALF_CYC, `SLC_FAST_HALF_CYC};
  logic [1:0] phase;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_flash
      logic [23:0] cnt, next_cnt;
      logic ph, next_ph;
      always_comb begin
        next_cnt = cnt + 24'h1;
        next_ph = ph;
        if (cnt == 24'(HALF[g] - 1)) begin
          next_cnt = 24'h0;
          next_ph = ~ph;
        end
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt <= 24'h0;
          ph <= 1'b0;
        end else begin
          cnt <= next_cnt;
          ph <= next_ph;
        end
      end
      assign phase[g] = ph;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Priority encoder: earlier branches win over later ones.
  function automatic slc_code_t slc_pick(slc_status_t s, logic link,
                                         logic bound);
    slc_code_t c;
    c = '{SLC_BLUE, SLC_SLOW};
    if (s.not_init) c = '{SLC_RED, SLC_STEADY};
    else if (s.init_fail) c = '{SLC_RED, SLC_SLOW};
    else if (s.over_temp) c = '{SLC_RED, SLC_FAST};
    else if (!link) c = '{SLC_BLUE, SLC_FAST};
    else if (bound && s.acq_free_run) c = '{SLC_GREEN, SLC_FAST};
    else if (bound && s.acq_triggered) c = '{SLC_GREEN, SLC_SLOW};
    else if (bound && s.app_connected) c = '{SLC_GREEN, SLC_STEADY};
    else if (bound) c = '{SLC_BLUE, SLC_STEADY};
    return c;
  endfunction

  slc_code_t code;
  logic lit;
  logic next_red, next_green, next_blue;
  always_comb begin
    code = slc_pick(status, link_s2, ip_valid);
    unique case (code.blink)
      SLC_SLOW: lit = phase[0];
      SLC_FAST: lit = phase[1];
      default: lit = 1'b1;
    endcase
    next_red = lit && code.colour == SLC_RED;
    next_green = lit && code.colour == SLC_GREEN;
    next_blue = lit && code.colour == SLC_BLUE;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_red <= 1'b0;
      led_green <= 1'b0;
      led_blue <= 1'b0;
    end else begin
      led_red <= next_red;
      led_green <= next_green;
      led_blue <= next_blue;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks tying outputs to their causes.
  property p_red_first;
    @(posedge core_clk) disable iff (!rst_n)
    status.not_init |=> led_red && !led_green && !led_blue;
  endproperty
  a_red_first: assert property (p_red_first) else $error("red not shown");

  property p_accept;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(host_ctrl_accept) |->
      $past(state) inside {SLC_STATIC, SLC_DHCP_WAIT, SLC_LL_WAIT};
  endproperty
  a_accept: assert property (p_accept) else $error("early host accept");

  property p_nolink;
    @(posedge core_clk) disable iff (!rst_n)
    (!link_s2 && !status.not_init && !status.init_fail && !status.over_temp)
      |=> !led_green && !led_red;
  endproperty
  a_nolink: assert property (p_nolink) else $error("no-link colour wrong");

  property p_static;
    @(posedge core_clk) disable iff (!rst_n)
    (state == SLC_STATIC && static_en && link_s2 && !link_rise)
      |=> ip_valid && ip_addr == $past(static_addr);
  endproperty
  a_static: assert property (p_static) else $error("static not taken");

  property p_restart;
    @(posedge core_clk) disable iff (!rst_n)
    link_rise |=> state == SLC_STATIC;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on link");

  property p_ll_prefix;
    @(posedge core_clk) disable iff (!rst_n)
    net_req.arp_probe |-> net_req.probe_addr[31:16] == `SLC_LL_PREFIX;
  endproperty
  a_ll_prefix: assert property (p_ll_prefix) else $error("bad probe prefix");

  property p_reprobe;
    @(posedge core_clk) disable iff (!rst_n)
    (state == SLC_LL_WAIT && net_ans.arp_done && net_ans.arp_reply && link_s2
      && !link_rise) |=> state == SLC_LL_PICK ##0 !ip_valid;
  endproperty
  a_reprobe: assert property (p_reprobe) else $error("reply not honoured");

  property p_steady_blue;
    @(posedge core_clk) disable iff (!rst_n)
    (ip_valid && link_s2 && status == '0) |=> led_blue;
  endproperty
  a_steady_blue: assert property (p_steady_blue) else $error("not blue");

endmodule
`default_nettype wire

/* File: core/slc_defs.svh */
// Timing and address constants for the status indicator and address sequencer.
`ifndef SLC_DEFS_SVH
`define SLC_DEFS_SVH
`define SLC_CLK_HZ 20000000
// Half-period of the slow flash, in milliseconds.
`define SLC_SLOW_HALF_MS 500
// Half-period of the fast flash, in milliseconds.
`define SLC_FAST_HALF_MS 125
`define SLC_SLOW_HALF_CYC ((`SLC_CLK_HZ / 1000) * `SLC_SLOW_HALF_MS)
`define SLC_FAST_HALF_CYC ((`SLC_CLK_HZ / 1000) * `SLC_FAST_HALF_MS)
// Link-local subnet prefix, upper 16 bits of the address.
`define SLC_LL_PREFIX 16'ha9fe
// Seed for the address generator.
`define SLC_LFSR_SEED 16'h5a3c
// Taps for a maximal 16-bit Galois generator.
`define SLC_LFSR_TAPS 16'hb400
`endif

/* File: core/slc_pkg.sv */
// Types shared by the status indicator and address sequencer.
`default_nettype none
package slc_pkg;
  typedef enum logic [1:0] {SLC_OFF, SLC_RED, SLC_BLUE, SLC_GREEN} slc_colour_t;
  typedef enum logic [1:0] {SLC_STEADY, SLC_SLOW, SLC_FAST} slc_blink_t;
  typedef struct packed {
    slc_colour_t colour;
    slc_blink_t blink;
  } slc_code_t;
  // Status inputs that pick the indicator pattern.
  typedef struct packed {
    logic not_init;
    logic init_fail;
    logic over_temp;
    logic app_connected;
    logic acq_triggered;
    logic acq_free_run;
  } slc_status_t;
  // Request to and answer from the network engine.
  typedef struct packed {
    logic dhcp_start;
    logic arp_probe;
    logic [31:0] probe_addr;
  } slc_net_req_t;
  typedef struct packed {
    logic dhcp_done;
    logic dhcp_fail;
    logic [31:0] dhcp_addr;
    logic arp_done;
    logic arp_reply;
  } slc_net_ans_t;
endpackage
`default_nettype wire

/* File: verification/slc_net_model.sv */
// Behavioural network engine: answers address-server and probe requests.
`default_nettype none
module slc_net_model
  import slc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire slc_net_req_t net_req,
  input wire logic srv_present,
  input wire logic slow,
  input wire logic [1:0] n_replies,
  input wire logic [31:0] offer_addr,
  output slc_net_ans_t net_ans,
  output var int n_dhcp,
  output var int n_probe
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt;
  logic busy_dhcp;
  logic busy_arp;
  ////////////////////////////////////////////////////////////////////////
  // Answer each request after a prompt or slow delay; the data lines churn
  // outside their pulses so a stale value can never look valid.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n || clr) begin
      net_ans <= '0;
      n_dhcp <= 0;
      n_probe <= 0;
      busy_dhcp <= 1'b0;
      busy_arp <= 1'b0;
      wait_cnt <= 0;
    end else begin
      net_ans.dhcp_done <= 1'b0;
      net_ans.dhcp_fail <= 1'b0;
      net_ans.arp_done <= 1'b0;
      net_ans.dhcp_addr <= ~net_ans.dhcp_addr;
      net_ans.arp_reply <= ~net_ans.arp_reply;
      if (net_req.dhcp_start) begin
        busy_dhcp <= 1'b1;
        wait_cnt <= slow ? 40 : 1;
        n_dhcp <= n_dhcp + 1;
      end else if (net_req.arp_probe) begin
        busy_arp <= 1'b1;
        wait_cnt <= slow ? 40 : 1;
        n_probe <= n_probe + 1;
      end else if (wait_cnt > 1) begin
        wait_cnt <= wait_cnt - 1;
      end else if (busy_dhcp) begin
        busy_dhcp <= 1'b0;
        net_ans.dhcp_done <= srv_present;
        net_ans.dhcp_fail <= !srv_present;
        net_ans.dhcp_addr <= offer_addr;
      end else if (busy_arp) begin
        busy_arp <= 1'b0;
        net_ans.arp_done <= 1'b1;
        net_ans.arp_reply <= (n_probe <= n_replies);
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the status indicator and address sequencer.
`default_nettype none
module tb_top
  import slc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, link_up_pin, static_en, dhcp_en, clr, srv, slow, smp;
  logic ip_valid, host_ctrl_accept, led_red, led_green, led_blue, v_prev;
  logic [31:0] static_addr, ip_addr, offer;
  logic [1:0] n_rep;
  logic [3:0] lexp;
  logic [63:0] aexp;
  slc_status_t status;
  slc_net_req_t net_req;
  slc_net_ans_t net_ans;
  int n_dhcp, n_probe, num_errors, n_compared, cyc;
  logic [63:0] q_addr[$];
  logic [3:0] q_led[$];
  slc_top uut (.core_clk(core_clk), .rst_n(rst_n), .link_up_pin(link_up_pin),
    .status(status), .static_en(static_en), .dhcp_en(dhcp_en),
    .static_addr(static_addr), .net_ans(net_ans), .net_req(net_req),
    .ip_addr(ip_addr), .ip_valid(ip_valid),
    .host_ctrl_accept(host_ctrl_accept), .led_red(led_red),
    .led_green(led_green), .led_blue(led_blue));
  slc_net_model net (.core_clk(core_clk), .rst_n(rst_n), .clr(clr),
    .net_req(net_req), .srv_present(srv), .slow(slow), .n_replies(n_rep),
    .offer_addr(offer), .net_ans(net_ans), .n_dhcp(n_dhcp),
    .n_probe(n_probe));
  ////////////////////////////////////////////////////////////////////////
  // Clock at 20 MHz.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Reporting and verdict; unconsumed expectations count as misses.
  task automatic miss(input string what, input logic [31:0] e, s);
    num_errors++;
    $display("wrong value %s expected %h seen %h", what, e, s);
  endtask
  task automatic tally_and_finish();
    num_errors += q_addr.size() + q_led.size();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_bit(input string what, input logic e, s);
    n_compared++;
    if (s !== e) miss(what, 32'(e), 32'(s));
  endtask
  task automatic chk_int(input string what, input int e, s);
    n_compared++;
    if (s != e) miss(what, e, s);
  endtask
  task automatic chk_addr(input logic [31:0] m, v, s);
    n_compared++;
    if ((s & m) !== v) miss("ip_addr", v, s);
  endtask
  // A flashing pattern may be caught in its dark half, so off is allowed;
  // the encoder's chosen code is read too, as the lamp alone cannot tell
  // slow from fast within a short run.
  task automatic chk_led(input slc_code_t e, input logic [2:0] s);
    logic [2:0] rgb;
    rgb = {e.colour == SLC_RED, e.colour == SLC_GREEN, e.colour == SLC_BLUE};
    n_compared++;
    if (s !== rgb && !(e.blink != SLC_STEADY && s === 3'h0)) begin
      miss("led", {29'h0, rgb}, {29'h0, s});
    end
    n_compared++;
    if (uut.code !== e) miss("led_code", {28'h0, e}, {28'h0, uut.code});
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Monitor: each new address or sample strobe consumes the oldest note.
  always @(posedge core_clk) begin
    v_prev <= ip_valid;
    if (ip_valid === 1'b1 && v_prev !== 1'b1) begin
      if (q_addr.size() == 0) miss("unexpected_bind", 32'h0, ip_addr);
      else begin
        aexp = q_addr.pop_front();
        chk_addr(aexp[63:32], aexp[31:0], ip_addr);
      end
    end
    if (smp) begin
      lexp = q_led.pop_front();
      chk_led(lexp, {led_red, led_green, led_blue});
    end
  end
  // Hang guard well above the longest expected run.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Expect a colour and a blink pattern, in the encoder's own codes.
  task automatic exp_led(input slc_colour_t c, input slc_blink_t b);
    q_led.push_back({c, b});
    repeat (4) @(negedge core_clk);
    smp = 1'b1;
    @(negedge core_clk);
    smp = 1'b0;
  endtask
  // Drop the link, configure the far side, raise the link, await binding.
  task automatic run_cfg(input logic se, de, sv, sl, input logic [1:0] nr,
                         input logic [31:0] m, v, input int ed, ep);
    int t;
    link_up_pin = 1'b0;
    clr = 1'b1;
    {static_en, dhcp_en, srv, slow, n_rep} = {se, de, sv, sl, nr};
    repeat (4) @(negedge core_clk);
    clr = 1'b0;
    chk_bit("accept_unbound", 1'b0, host_ctrl_accept);
    q_addr.push_back({m, v});
    link_up_pin = 1'b1;
    if (sl) begin
      repeat (12) @(negedge core_clk);
      chk_bit("accept_waiting", 1'b0, host_ctrl_accept);
      exp_led(SLC_BLUE, SLC_SLOW);
    end
    for (t = 0; t < 2000 && ip_valid !== 1'b1; t++) @(negedge core_clk);
    chk_bit("accept_bound", 1'b1, host_ctrl_accept);
    chk_int("dhcp_starts", ed, n_dhcp);
    chk_int("probes", ep, n_probe);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence, inputs changed at the falling edge.
  initial begin
    {rst_n, link_up_pin, static_en, clr, srv, slow, smp, n_rep} = '0;
    {dhcp_en, clr} = 2'h3;
    status = '0;
    status.not_init = 1'b1;
    void'($urandom(77636));
    static_addr = $urandom;
    offer = $urandom;
    repeat (20) @(negedge core_clk);
    chk_bit("ip_valid_rst", 1'b0, ip_valid);
    rst_n = 1'b1;
    exp_led(SLC_RED, SLC_STEADY);
    status.not_init = 1'b0;
    exp_led(SLC_BLUE, SLC_FAST);
    run_cfg(1'b0, 1'b1, 1'b1, 1'b1, 2'h0, '1, offer, 1, 0);
    exp_led(SLC_BLUE, SLC_STEADY);
    status.acq_free_run = 1'b1;
    exp_led(SLC_GREEN, SLC_FAST);
    status = '0;
    status.acq_triggered = 1'b1;
    exp_led(SLC_GREEN, SLC_SLOW);
    status = '0;
    status.app_connected = 1'b1;
    exp_led(SLC_GREEN, SLC_STEADY);
    status.acq_free_run = 1'b1;
    status.over_temp = 1'b1;
    exp_led(SLC_RED, SLC_FAST);
    status.over_temp = 1'b0;
    status.init_fail = 1'b1;
    exp_led(SLC_RED, SLC_SLOW);
    status = '0;
    run_cfg(1'b1, 1'b1, 1'b1, 1'b0, 2'h0, '1, static_addr, 0, 0);
    n_rep = 2'($urandom_range(3, 1));
    run_cfg(1'b0, 1'b1, 1'b0, 1'b0, n_rep, 32'hffff0000, 32'ha9fe0000, 1,
            n_rep + 1);
    run_cfg(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 32'hffff0000, 32'ha9fe0000, 0,
            1);
    link_up_pin = 1'b0;
    repeat (6) @(negedge core_clk);
    chk_bit("ip_valid_drop", 1'b0, ip_valid);
    tally_and_finish();
  end
endmodule
`default_nettype wire
